// [sdm_consts.svh]
// sdm_consts.svh: constants of the step/direction microstep sequencer
// assumes: included by bare name from the package and the design module
`ifndef SDM_CONSTS_SVH
`define SDM_CONSTS_SVH

`define SDM_POS_W       10
`define SDM_RES_W       4
`define SDM_RES_FULL    4'h8
`define SDM_INT_W       20
`define SDM_INT_MAX     20'hfffff
`define SDM_POS_ZERO    10'h000
`define SDM_POS_RESET   10'h000
`define SDM_SUB_W       8
`define SDM_SUB_LAST    8'hff
`define SDM_CLK_PERIOD_NS 100

`endif

// [sdm_pkg.sv]
// sdm_pkg.sv: types of the step/direction microstep sequencer
// assumes: sdm_consts.svh is on the include path
`include "sdm_consts.svh"
package sdm_pkg;
	typedef struct packed {
		logic step;
		logic dir;
	} sdm_pins_type;

	typedef struct packed {
		logic                    stst;
		logic                    standby;
		logic                    index;
		logic [`SDM_POS_W-1:0]   pos;
	} sdm_status_type;

	typedef enum logic [1:0] {
		SDM_IDLE = 2'b00,
		SDM_RUN  = 2'b01,
		SDM_STST = 2'b11
	} sdm_state_type;
endpackage

// [sdm_sequencer.sv]
// sdm_sequencer.sv: step/direction front end with microstep interpolator
// assumes: step and dir come from pins, resolution and power-down select are static-ish levels
`timescale 1ns/10ps
`default_nettype none
`include "sdm_consts.svh"

// Functional notes
// - only rising step edges advance the sequencer
// - step and direction synchronised by two flip-flops
// - 1024-entry table indexed by position counter
// - direction 0 adds width, 1 subtracts
// - width is 1 to 256, doubling per setting
// - coarser resolution snaps to nearest valid position
// - full step visits 128,384,640,896 only
// - half step starts at 64, moves 128
// - quarter step starts at 32, moves 64
// - each edge with a measured interval starts a burst of 1 to 256 microsteps
// - microstep spacing is previous interval divided
// - measured interval saturates at 2^20-1 clocks (all ones)
// - no edge within limit raises standstill
// - standby reduction only when power-down select set
// - standstill flag clears on next active edge
// - faster rate adopted after one period
// - index marks position zero once per period
// - position counter wraps modulo 1024
module sdm_sequencer #(
	parameter int POS_W = `SDM_POS_W,
	parameter int INT_W = `SDM_INT_W
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset,
	// pins from the motion controller
	input  wire sdm_pkg::sdm_pins_type pins,
	// configuration levels
	input  wire logic [`SDM_RES_W-1:0] resolution,
	input  wire logic              power_down_select_pin,
	// sequencer outputs
	output logic [POS_W-1:0]       table_pos,
	output logic [POS_W-1:0]       input_pos,
	output logic                   index_out,
	output logic                   stst_flag,
	output logic                   standby_req,
	output logic                   microstep_pulse
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [1:0] step_sync_ff;
	logic [1:0] dir_sync_ff;
	logic       step_prev_ff;
	logic [`SDM_RES_W-1:0] res_ff;
	logic       pdn_sync0_ff;
	logic       pdn_ff;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			step_sync_ff <= 2'h0;
			dir_sync_ff  <= 2'h0;
			step_prev_ff <= 1'b0;
			pdn_sync0_ff <= 1'b0;
			pdn_ff       <= 1'b0;
			res_ff       <= 4'h0;
		end else begin
			step_sync_ff <= {step_sync_ff[0], pins.step};
			dir_sync_ff  <= {dir_sync_ff[0], pins.dir};
			step_prev_ff <= step_sync_ff[1];
			pdn_sync0_ff <= power_down_select_pin;
			pdn_ff       <= pdn_sync0_ff;
			res_ff       <= resolution;
		end
	end

	// falling edges are deliberately ignored
	wire step_edge = step_sync_ff[1] & ~step_prev_ff;
	wire dir_now   = dir_sync_ff[1];

	// ----------------------------------------
	// step width and snapping
	// ----------------------------------------
	// setting 0 is 256x, each increment doubles the width; clipped at full step
	function automatic logic [POS_W-1:0] width_of(input logic [`SDM_RES_W-1:0] r);
		logic [`SDM_RES_W-1:0] rc;
		rc = (r > `SDM_RES_FULL) ? `SDM_RES_FULL : r;
		width_of = POS_W'(1) << rc;
	endfunction

	// valid positions of a width w sit at odd multiples of w/2 (or any at width 1)
	function automatic logic [POS_W-1:0] snap(input logic [POS_W-1:0] p, input logic [POS_W-1:0] w);
		logic [POS_W-1:0] half;
		logic [POS_W-1:0] base;
		half = w >> 1;
		base = (p - half) & ~(w - POS_W'(1));
		if (((p - half - base) & (w - POS_W'(1))) >= half && w != POS_W'(1))
			base = base + w;
		snap = (w == POS_W'(1)) ? p : POS_W'(base + half);
	endfunction

	wire [POS_W-1:0] width_w  = width_of(res_ff);
	logic [`SDM_RES_W-1:0] res_prev_ff;
	logic [POS_W-1:0] in_pos_ff;
	wire coarser = res_ff > res_prev_ff;
	wire [POS_W-1:0] snapped = snap(in_pos_ff, width_w);
	// snap only on a coarser change; a finer setting keeps stepping from where it stands
	wire [POS_W-1:0] base_pos = coarser ? snapped : in_pos_ff;
	wire [POS_W-1:0] stepped = dir_now ? POS_W'(base_pos - width_w) : POS_W'(base_pos + width_w);
	wire [POS_W-1:0] nxt_in_pos = step_edge ? stepped : (coarser ? snapped : in_pos_ff);

	// ----------------------------------------
	// interval measurement and standstill
	// ----------------------------------------
	logic [INT_W-1:0] icnt_ff;
	logic [INT_W-1:0] last_int_ff;
	logic             valid_int_ff;
	logic             stst_ff;
	logic             standby_ff;
	sdm_pkg::sdm_state_type state_ff;

	// all ones is the longest interval the counter holds, whatever INT_W is set to
	wire icnt_sat = &icnt_ff;
	wire [INT_W-1:0] nxt_icnt = step_edge ? '0 : (icnt_sat ? icnt_ff : INT_W'(icnt_ff + 1'b1));
	wire stst_event = icnt_sat & ~stst_ff;
	sdm_pkg::sdm_state_type nxt_state;
	always_comb begin
		case (state_ff)
			sdm_pkg::SDM_IDLE: nxt_state = step_edge ? sdm_pkg::SDM_RUN : sdm_pkg::SDM_IDLE;
			sdm_pkg::SDM_RUN:  nxt_state = stst_event ? sdm_pkg::SDM_STST : sdm_pkg::SDM_RUN;
			sdm_pkg::SDM_STST: nxt_state = step_edge ? sdm_pkg::SDM_RUN : sdm_pkg::SDM_STST;
			default:           nxt_state = sdm_pkg::SDM_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			icnt_ff      <= '0;
			last_int_ff  <= '0;
			valid_int_ff <= 1'b0;
			stst_ff      <= 1'b0;
			standby_ff   <= 1'b0;
			state_ff     <= sdm_pkg::SDM_IDLE;
			res_prev_ff  <= 4'h0;
			in_pos_ff    <= `SDM_POS_RESET;
		end else begin
			icnt_ff     <= nxt_icnt;
			state_ff    <= nxt_state;
			res_prev_ff <= res_ff;
			in_pos_ff   <= nxt_in_pos;
			if (step_edge) begin
				// the very first edge only opens a measurement window
				last_int_ff  <= icnt_ff;
				valid_int_ff <= (state_ff == sdm_pkg::SDM_RUN) & ~icnt_sat;
				stst_ff      <= 1'b0;
				standby_ff   <= 1'b0;
			end else if (icnt_sat) begin
				valid_int_ff <= 1'b0;
				stst_ff      <= 1'b1;
				standby_ff   <= pdn_ff;
			end
		end
	end

	// ----------------------------------------
	// microstep interpolator
	// ----------------------------------------
	// spacing = interval/256 in clocks; a fresh edge restarts the burst so
	// unissued microsteps from a slow period are dropped (small angle jump)
	wire [INT_W-1:0] spacing = {8'h00, last_int_ff[INT_W-1:`SDM_SUB_W]};
	logic [INT_W-1:0] tick_ff;
	logic [POS_W-1:0] out_pos_ff;
	logic [POS_W-1:0] left_ff;
	logic             dir_out_ff;
	logic             mstep_ff;
	logic             index_ff;

	wire tick_done = (tick_ff >= spacing);
	wire emit = (left_ff != '0) & tick_done & valid_int_ff;
	wire [POS_W-1:0] nxt_out = dir_out_ff ? POS_W'(out_pos_ff - 1'b1) : POS_W'(out_pos_ff + 1'b1);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tick_ff    <= '0;
			out_pos_ff <= `SDM_POS_RESET;
			left_ff    <= '0;
			dir_out_ff <= 1'b0;
			mstep_ff   <= 1'b0;
			index_ff   <= 1'b0;
		end else begin
			mstep_ff <= emit;
			if (step_edge || coarser) begin
				// jump to the input's current snapped vector, then interpolate toward the next
				// a coarser change cancels a running burst so the snapped vector shows at once
				out_pos_ff <= step_edge ? base_pos : nxt_in_pos;
				dir_out_ff <= dir_now;
				tick_ff    <= '0;
				left_ff    <= (step_edge && valid_int_ff) ? width_w : '0;
				if (step_edge && !valid_int_ff)
					out_pos_ff <= stepped;
			end else if (emit) begin
				out_pos_ff <= nxt_out;
				left_ff    <= POS_W'(left_ff - 1'b1);
				tick_ff    <= '0;
			end else begin
				tick_ff <= tick_done ? tick_ff : INT_W'(tick_ff + 1'b1);
			end
			index_ff <= (out_pos_ff == `SDM_POS_ZERO);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign table_pos       = out_pos_ff;
	assign input_pos       = in_pos_ff;
	assign index_out       = index_ff;
	assign stst_flag       = stst_ff;
	assign standby_req     = standby_ff;
	assign microstep_pulse = mstep_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_rise_only;
		@(posedge clk_sys) disable iff (reset)
		(step_sync_ff[1] != step_prev_ff && step_prev_ff) |=> ($stable(in_pos_ff) || $past(coarser));
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("falling edge moved position");

	property p_sync;
		@(posedge clk_sys) disable iff (reset)
		$rose(step_sync_ff[1]) |-> $past(pins.step, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("step not delayed by two stages");

	property p_dir_up;
		@(posedge clk_sys) disable iff (reset)
		(step_edge && !dir_now) |=> in_pos_ff == POS_W'($past(base_pos) + $past(width_w));
	endproperty
	a_dir_up: assert property (p_dir_up) else $error("up count wrong");

	property p_dir_dn;
		@(posedge clk_sys) disable iff (reset)
		(step_edge && dir_now) |=> in_pos_ff == POS_W'($past(base_pos) - $past(width_w));
	endproperty
	a_dir_dn: assert property (p_dir_dn) else $error("down count wrong");

	property p_full;
		@(posedge clk_sys) disable iff (reset)
		(res_ff == `SDM_RES_FULL && res_prev_ff == `SDM_RES_FULL && $past(res_ff) == `SDM_RES_FULL)
			|-> in_pos_ff[7:0] == 8'h80 || $past(step_edge) == 1'b0;
	endproperty
	a_full: assert property (p_full) else $error("full step off grid");

	property p_stst_set;
		@(posedge clk_sys) disable iff (reset)
		(icnt_sat && !step_edge) |=> stst_ff;
	endproperty
	a_stst_set: assert property (p_stst_set) else $error("standstill not flagged");

	property p_stst_clr;
		@(posedge clk_sys) disable iff (reset)
		step_edge |=> !stst_ff && !standby_ff;
	endproperty
	a_stst_clr: assert property (p_stst_clr) else $error("standstill not cleared");

	property p_standby;
		@(posedge clk_sys) disable iff (reset)
		standby_ff |-> stst_ff && pdn_ff;
	endproperty
	a_standby: assert property (p_standby) else $error("standby without select");

	sequence s_edge_no_int;
		step_edge && !valid_int_ff;
	endsequence
	property p_first;
		@(posedge clk_sys) disable iff (reset)
		s_edge_no_int |=> !mstep_ff [*2];
	endproperty
	a_first: assert property (p_first) else $error("microstep before interval known");

	property p_index;
		@(posedge clk_sys) disable iff (reset)
		(out_pos_ff == `SDM_POS_ZERO) |=> index_ff;
	endproperty
	a_index: assert property (p_index) else $error("index missed zero");

	property p_index_clr;
		@(posedge clk_sys) disable iff (reset)
		(out_pos_ff != `SDM_POS_ZERO) |=> !index_ff;
	endproperty
	a_index_clr: assert property (p_index_clr) else $error("index away from zero");

	property p_snap_grid;
		@(posedge clk_sys) disable iff (reset)
		coarser |=> (in_pos_ff & POS_W'($past(width_w) - 1'b1)) == POS_W'($past(width_w) >> 1);
	endproperty
	a_snap_grid: assert property (p_snap_grid) else $error("coarser change left position off grid");

	property p_wrap;
		@(posedge clk_sys) disable iff (reset)
		(emit && !step_edge && !coarser && !dir_out_ff && out_pos_ff == '1) |=> out_pos_ff == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("table position did not wrap");

	property p_mstep_valid;
		@(posedge clk_sys) disable iff (reset)
		mstep_ff |-> $past(valid_int_ff);
	endproperty
	a_mstep_valid: assert property (p_mstep_valid) else $error("microstep without measured interval");

	property p_sat_hold;
		@(posedge clk_sys) disable iff (reset)
		(icnt_sat && !step_edge) |=> icnt_sat;
	endproperty
	a_sat_hold: assert property (p_sat_hold) else $error("interval counter left saturation");

	property p_dir_hold;
		@(posedge clk_sys) disable iff (reset)
		step_edge |=> dir_out_ff == $past(dir_now);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("burst direction not taken at edge");

	property p_standby_set;
		@(posedge clk_sys) disable iff (reset)
		(icnt_sat && !step_edge && pdn_ff) |=> standby_ff;
	endproperty
	a_standby_set: assert property (p_standby_set) else $error("standby not requested");

	property p_first_jump;
		@(posedge clk_sys) disable iff (reset)
		s_edge_no_int |=> out_pos_ff == in_pos_ff;
	endproperty
	a_first_jump: assert property (p_first_jump) else $error("table did not jump whole width");

	// emits since the last restart never exceed the width taken at that restart
	logic [POS_W-1:0] burst_cnt_ff;
	logic [POS_W-1:0] burst_w_ff;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			burst_cnt_ff <= '0;
			burst_w_ff   <= '0;
		end else if (step_edge || coarser) begin
			burst_cnt_ff <= '0;
			burst_w_ff   <= width_w;
		end else begin
			burst_cnt_ff <= POS_W'(burst_cnt_ff + emit);
		end
	end

	property p_burst_len;
		@(posedge clk_sys) disable iff (reset)
		burst_cnt_ff <= burst_w_ff;
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("too many microsteps in burst");
endmodule
`default_nettype wire

// [sdm_ctrl_model.sv]
// sdm_ctrl_model.sv: motion controller model driving step and direction pins
// assumes: the bench calls do_step and keeps step spacing within the rate limit
`timescale 1ns/10ps
`default_nettype none
module sdm_ctrl_model (
	// clock
	input  wire logic                  clk_sys,
	// pins toward the sequencer
	output var  sdm_pkg::sdm_pins_type pins
);
	initial pins = '0;
	// ---------------------------------------------
	// one step pulse
	// ---------------------------------------------
	// direction settles a cycle ahead and is held well past the low time
	task automatic do_step(input logic d, input int hi, input int lo);
		@(posedge clk_sys) #1;
		pins.dir = d;
		@(posedge clk_sys) #1;
		pins.step = 1'b1;
		repeat (hi) @(posedge clk_sys);
		#1 pins.step = 1'b0;
		repeat (lo) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// [tb.sv]
// tb.sv: self-checking bench of the step/direction microstep sequencer
// assumes: design files and sdm_ctrl_model.sv compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "sdm_consts.svh"
module tb;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic                  clk_sys, reset, pdsel, index_out, stst_flag, standby_req, microstep_pulse;
	logic [`SDM_RES_W-1:0] res;
	logic [9:0]            table_pos, input_pos, exp_pos, tp_d;
	logic [31:0]           rnd;
	sdm_pkg::sdm_pins_type pins;
	int                    n_errors, comparisons, n_pulse, rst_age, n;

	sdm_ctrl_model u_ctrl (.clk_sys(clk_sys), .pins(pins));
	// short interval counter keeps standstill near a thousand clocks
	sdm_sequencer #(.INT_W(10)) u_dut (.clk_sys(clk_sys), .reset(reset), .pins(pins), .resolution(res),
		.power_down_select_pin(pdsel), .table_pos(table_pos), .input_pos(input_pos), .index_out(index_out),
		.stst_flag(stst_flag), .standby_req(standby_req), .microstep_pulse(microstep_pulse));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// ---------------------------------------------
	// expectations
	// ---------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// nearest odd multiple of half the width, ties upward
	function automatic logic [9:0] snap(input logic [9:0] p, input int r);
		logic [9:0] w;
		w = 10'h001 << r;
		if (r == 0) return p;
		return (p & ~(w - 10'h001)) + (w >> 1);
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ---------------------------------------------
	// stimulus tasks
	// ---------------------------------------------
	// the falling edge lands before the compare, so only the rise may count
	task automatic step(input logic d, input int lo);
		u_ctrl.do_step(d, 2, lo);
		exp_pos = d ? exp_pos - (10'h001 << res) : exp_pos + (10'h001 << res);
		#1 check("input_pos", input_pos, exp_pos);
	endtask
	task automatic set_res(input int r);
		@(posedge clk_sys) #1;
		if (r > res) exp_pos = snap(exp_pos, r);
		res = r[3:0];
		// the next step must not beat the full-step rate of the new setting
		repeat (4 + (2 << r)) @(posedge clk_sys);
		#1 check("snap", input_pos, exp_pos);
	endtask
	task automatic wait_stst(input logic pd);
		pdsel = pd;
		step(1'b0, 3);
		n = 0;
		while (stst_flag !== 1'b1 && n < 1100) begin
			@(posedge clk_sys) #1;
			n++;
		end
		check("stst_time", (n > 1000 && n < 1030), 1);
		if (n >= 1100) complete_run();
		check("standby", standby_req, pd);
		step(1'b0, 515);
		check("stst_clear", {stst_flag, standby_req}, 0);
	endtask
	// ---------------------------------------------
	// monitors
	// ---------------------------------------------
	always @(posedge clk_sys) begin
		if (rst_age > 2) check("index_out", index_out, tp_d == 10'h000);
		if (microstep_pulse === 1'b1) n_pulse++;
		tp_d <= table_pos;
		rst_age <= reset ? 0 : rst_age + 1;
	end
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		reset = 1'b1;
		pdsel = 1'b0;
		res = 4'h0;
		exp_pos = 10'h000;
		rnd = 32'h6b7f;
		n_errors = 0;
		comparisons = 0;
		n_pulse = 0;
		rst_age = 0;
		repeat (8) @(posedge clk_sys);
		#1 reset = 1'b0;
		@(posedge clk_sys) #1;
		check("reset_out", {table_pos, input_pos, stst_flag, standby_req, microstep_pulse}, 0);
		step(1'b1, 3);
		step(1'b0, 3);
		set_res(2);
		step(1'b0, 11);
		set_res(7);
		step(1'b0, 259);
		set_res(8);
		for (int i = 0; i < 5; i++) step(1'b0, 515);
		step(1'b1, 515);
		wait_stst(1'b1);
		wait_stst(1'b0);
		// two steps to measure the interval, then two timed ones
		set_res(4);
		step(1'b0, 397);
		step(1'b0, 397);
		n_pulse = 0;
		step(1'b0, 397);
		step(1'b0, 397);
		check("pulses", n_pulse, 32);
		check("table_pos", table_pos, exp_pos);
		for (int i = 0; i < 40; i++) begin
			rnd = xs(rnd);
			set_res(rnd[7:0] % 9);
			step(rnd[8], 2 * (1 << res) + 3 + rnd[12:10]);
		end
		complete_run();
	end
endmodule
`default_nettype wire
